// ### rtl/pcm_tdm_pkg.sv
// Purpose : shared constants and types of the transmit pcm framer
// Assumes : 125 MHz system clock, 2,304 kHz digit rate
// Notes   : the digit rate is made by a phase accumulator; digit edges jitter by one clock

package pcm_tdm_pkg;

  // ==========================================================================
  // clocking and rates
  localparam int unsigned CLK_KHZ       = 125000;
  localparam int unsigned DIGIT_KHZ     = 2304;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ACC_W         = 17;
  localparam logic [16:0] ACC_MOD       = 17'(CLK_KHZ);
  localparam logic [16:0] ACC_STEP      = 17'(DIGIT_KHZ);
  localparam logic [16:0] ACC_HALF      = 17'(CLK_KHZ / 2);
  localparam logic [16:0] ACC_ZERO      = 17'h00000;

  // ==========================================================================
  // frame layout
  localparam int unsigned CHANNELS   = 48;
  localparam int unsigned DIGITS     = 6;
  localparam int unsigned CODE_W     = 6;
  localparam int unsigned SAMPLE_W   = 8;
  localparam int unsigned DIGIT_W    = 3;
  localparam int unsigned CHAN_W     = 6;
  localparam logic [2:0]  LAST_DIGIT = 3'(DIGITS - 1);
  localparam logic [5:0]  LAST_CHAN  = 6'(CHANNELS - 1);
  localparam logic [2:0]  DIGIT_ZERO = 3'h0;
  localparam logic [5:0]  CHAN_ZERO  = 6'h00;
  localparam logic [5:0]  CODE_ZERO  = 6'h00;
  localparam logic [5:0]  STEP_FIRST = 6'h01;
  localparam int unsigned CODE_LSB   = SAMPLE_W - CODE_W;

  // ==========================================================================
  // slave sync supervision
  localparam int unsigned SYNC_LOSS_NS  = 2000;
  localparam int unsigned SYNC_LOSS_CYC = (SYNC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SYNC_LOSS_MAX = 8'(SYNC_LOSS_CYC);
  localparam logic [7:0]  LOSS_ZERO     = 8'h00;

  // ==========================================================================
  // types
  typedef logic [SAMPLE_W-1:0]               sample_t;
  typedef logic [CODE_W-1:0]                 code_t;
  typedef sample_t [CHANNELS-1:0]            audio_t;

  typedef struct packed {
    logic         word_rate_timing;    // one pulse at each word start
    logic         channel_rate_signal; // 384 kHz square
    logic         odd_strobe;          // 192 kHz odd line capture
    logic         even_strobe;         // 192 kHz even line capture
    logic [5:0]   step;                // bit 0 first_step_pulse .. bit 5 sixth_step_pulse
  } tx_timing_t;

  typedef struct packed {
    logic [16:0]  acc;
    logic [2:0]   digit;
    logic [5:0]   chan;
    logic [1:0]   frame;
    sample_t      odd_hold;
    sample_t      even_hold;
    code_t        clamp;
    logic         pcm;
    logic         sync_out;
    logic         sync_prev;
    logic [7:0]   loss_cnt;
    tx_timing_t   tim;
  } tx_state_t;

  typedef struct packed {
    logic [5:0]          cnt;
    logic [CHANNELS-1:0] strobe;
  } modem_state_t;

endpackage : pcm_tdm_pkg

// ### rtl/modem_timing_matrix.sv
// Purpose : second countdown chain and decoding matrix for modulator sampling strobes
// Assumes : modem_tick_i is a one-cycle pulse at channel rate
// Notes   : each strobe is one clock wide, once per 48 ticks, i.e. 8 kHz

`timescale 1ns/10ps
`default_nettype none

module modem_timing_matrix (
  input  wire logic                               clk_i,
  input  wire logic                               rstn_i,
  input  wire logic                               modem_tick_i,
  output logic [pcm_tdm_pkg::CHANNELS-1:0]        modulator_strobe_o
);

  pcm_tdm_pkg::modem_state_t s_reg;
  pcm_tdm_pkg::modem_state_t s_next;

  // ==========================================================================
  // countdown and decode
  always_comb begin
    s_next        = s_reg;
    s_next.strobe = '0;
    if (modem_tick_i) begin
      s_next.strobe[s_reg.cnt] = 1'b1;
      if (s_reg.cnt == pcm_tdm_pkg::LAST_CHAN) begin
        s_next.cnt = pcm_tdm_pkg::CHAN_ZERO;
      end else begin
        s_next.cnt = s_reg.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign modulator_strobe_o = s_reg.strobe;

  // ==========================================================================
  // checks
  property p_strobe_decode;
    @(posedge clk_i) disable iff (!rstn_i)
      modem_tick_i |=> $onehot(modulator_strobe_o)
                       && modulator_strobe_o[$past(s_reg.cnt)];
  endproperty
  a_strobe_decode: assert property (p_strobe_decode)
    else $error("modulator strobe does not match countdown");

endmodule : modem_timing_matrix

`default_nettype wire

// ### rtl/pcm_tdm_transmit_framer.sv
// Purpose : transmit side of a 48-channel pcm multiplexer: timing, sampling, coding, address
// Assumes : audio_i holds one unsigned sample per channel; sync_i is synchronous to clk_i
// Notes   : the compander is not modelled; the code word is the six top sample bits
//
// Summary of operation
// - take 48 channels, sample each once per 8 kHz frame into one sequence.
// - convert each time-division sample into a six-digit binary code word.
// - handle channels as 24 odd/even pairs on two separate sample lines.
// - capture odd and even lines alternately with interleaved 192 kHz strobes.
// - coder is successive approximation: clamp bits, ladder compare, decision.
// - six step pulses fire in order per word, each setting its clamp bit.
// - step pulses come from word timing; decisions from reshaped master clock.
// - decisions are registered; serial stream leaves at 2,304 kHz digit rate.
// - output inserts 4 kHz address as master or 2 kHz as slave.
// - all transmit timing counts down from one master clock.
// - slave basic clock follows master's 2,304 kHz sync so timing stays aligned.
// - master drives a 2,304 kHz sync output from its countdown chain.
// - received sync feeds automatic switch locking the basic clock to it.
// - in a 48-channel system run from own master clock only.
// - countdown makes a 384 kHz word-rate pulse used as modem timing.
// - second countdown from modem timing feeds matrix of 8 kHz strobes.
// - frame address occupies the last digit of channel 48's word.
// - 96-channel line interleaves two streams, master 4 kHz and slave 2 kHz.
// - in a 48-channel system the address is always master.

`timescale 1ns/10ps
`default_nettype none

module pcm_tdm_transmit_framer (
  input  wire logic                               clk_i,
  input  wire logic                               rstn_i,
  input  wire pcm_tdm_pkg::audio_t                audio_i,
  input  wire logic                               system_96_i,
  input  wire logic                               master_sel_i,
  input  wire logic                               sync_i,
  output logic                                    pcm_o,
  output logic                                    sync_o,
  output logic                                    sync_locked_o,
  output pcm_tdm_pkg::tx_timing_t                 timing_o,
  output logic [pcm_tdm_pkg::CHANNELS-1:0]        modulator_strobe_o
);

  pcm_tdm_pkg::tx_state_t s_reg;
  pcm_tdm_pkg::tx_state_t s_next;

  logic        acting_master;
  logic        follow_sync;
  logic        sync_rise;
  logic [17:0] acc_sum;
  logic        digit_tick;
  logic        decide_tick;
  logic        decide_now;
  logic        address_bit;
  logic [2:0]  bit_pos;
  logic [2:0]  next_digit;
  logic [5:0]  next_chan;
  pcm_tdm_pkg::sample_t line_sample;
  pcm_tdm_pkg::code_t   held_code;

  // ==========================================================================
  // mode selection
  // a 48-channel system is always master, whatever the address selector says
  assign acting_master = !system_96_i || master_sel_i;
  // only a 96-channel slave listens to the sync input
  assign follow_sync   = system_96_i && !master_sel_i;
  assign sync_rise     = sync_i && !s_reg.sync_prev;

  // address pattern: 1010.. over frames for master, 1100.. for slave
  assign address_bit   = acting_master ? !s_reg.frame[0] : !s_reg.frame[1];

  // ==========================================================================
  // master clock countdown: phase accumulator at the digit rate
  assign acc_sum     = {1'b0, s_reg.acc} + {1'b0, pcm_tdm_pkg::ACC_STEP};
  assign digit_tick  = (acc_sum >= {1'b0, pcm_tdm_pkg::ACC_MOD});
  // decision strobe sits at mid-digit, half a period after the step pulse
  assign decide_tick = (s_reg.acc < pcm_tdm_pkg::ACC_HALF)
                       && (acc_sum >= {1'b0, pcm_tdm_pkg::ACC_HALF});
  // a slave snap lands at mid-digit; if this digit has not decided yet it decides now,
  // otherwise every snap that arrives a step early would swallow the digit
  assign decide_now  = (follow_sync && sync_rise) ? (s_reg.acc < pcm_tdm_pkg::ACC_HALF)
                                                  : decide_tick;

  always_comb begin
    if (s_reg.digit == pcm_tdm_pkg::LAST_DIGIT) begin
      next_digit = pcm_tdm_pkg::DIGIT_ZERO;
    end else begin
      next_digit = s_reg.digit + 3'h1;
    end
    if (s_reg.chan == pcm_tdm_pkg::LAST_CHAN) begin
      next_chan = pcm_tdm_pkg::CHAN_ZERO;
    end else begin
      next_chan = s_reg.chan + 6'h01;
    end
  end

  // coder input line: channel index 0 is channel 1, the first odd channel
  assign line_sample = s_reg.chan[0] ? s_reg.even_hold : s_reg.odd_hold;
  assign held_code   = line_sample[pcm_tdm_pkg::CODE_LSB +: pcm_tdm_pkg::CODE_W];
  assign bit_pos     = pcm_tdm_pkg::LAST_DIGIT - s_reg.digit;

  // ==========================================================================
  // next state
  always_comb begin
    s_next                         = s_reg;
    s_next.tim.word_rate_timing    = 1'b0;
    s_next.tim.odd_strobe          = 1'b0;
    s_next.tim.even_strobe         = 1'b0;
    s_next.tim.step                = pcm_tdm_pkg::CODE_ZERO;
    s_next.sync_prev               = sync_i;
    s_next.sync_out                = (s_reg.acc >= pcm_tdm_pkg::ACC_HALF);
    s_next.tim.channel_rate_signal = (s_reg.digit < 3'(pcm_tdm_pkg::DIGITS / 2));

    if (sync_rise) begin
      s_next.loss_cnt = pcm_tdm_pkg::LOSS_ZERO;
    end else if (s_reg.loss_cnt != pcm_tdm_pkg::SYNC_LOSS_MAX) begin
      s_next.loss_cnt = s_reg.loss_cnt + 8'h01;
    end

    if (follow_sync && sync_rise) begin
      // master sync rises at mid-digit; snap our phase there and skip this cycle's digit edge
      s_next.acc = pcm_tdm_pkg::ACC_HALF;
    end else begin
      if (digit_tick) begin
        s_next.acc = 17'(acc_sum - {1'b0, pcm_tdm_pkg::ACC_MOD});
      end else begin
        s_next.acc = acc_sum[16:0];
      end

      if (digit_tick) begin
        s_next.digit = next_digit;
        s_next.tim.step[next_digit] = 1'b1;
        if (next_digit == pcm_tdm_pkg::DIGIT_ZERO) begin
          // word boundary: new channel, capture its sample on its own line
          s_next.tim.word_rate_timing = 1'b1;
          s_next.chan = next_chan;
          if (next_chan == pcm_tdm_pkg::CHAN_ZERO) begin
            s_next.frame = s_reg.frame + 2'h1;
          end
          if (next_chan[0]) begin
            s_next.even_hold       = audio_i[next_chan];
            s_next.tim.even_strobe = 1'b1;
          end else begin
            s_next.odd_hold        = audio_i[next_chan];
            s_next.tim.odd_strobe  = 1'b1;
          end
          s_next.clamp = pcm_tdm_pkg::CODE_ZERO;
          s_next.clamp[pcm_tdm_pkg::LAST_DIGIT] = 1'b1;
        end else begin
          s_next.clamp[pcm_tdm_pkg::LAST_DIGIT - next_digit] = 1'b1;
        end
      end

    end

    if (decide_now) begin
      // ladder compare: keep the trial bit only if the sample reaches it
      if (held_code < s_reg.clamp) begin
        s_next.clamp[bit_pos] = 1'b0;
      end
      if ((s_reg.chan == pcm_tdm_pkg::LAST_CHAN)
          && (s_reg.digit == pcm_tdm_pkg::LAST_DIGIT)) begin
        s_next.pcm = address_bit;
      end else begin
        s_next.pcm = (held_code >= s_reg.clamp);
      end
    end
  end

  // counters start on the last digit of the last channel, so the first word after
  // reset is channel 0 and stays in step with the modulator strobe countdown
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg       <= '0;
      s_reg.digit <= pcm_tdm_pkg::LAST_DIGIT;
      s_reg.chan  <= pcm_tdm_pkg::LAST_CHAN;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs
  assign pcm_o         = s_reg.pcm;
  assign sync_o        = s_reg.sync_out;
  assign sync_locked_o = follow_sync && (s_reg.loss_cnt != pcm_tdm_pkg::SYNC_LOSS_MAX);
  assign timing_o      = s_reg.tim;

  // modem timing is the buffered word-rate pulse
  modem_timing_matrix u_modem_matrix (
    .clk_i              (clk_i),
    .rstn_i             (rstn_i),
    .modem_tick_i       (s_reg.tim.word_rate_timing),
    .modulator_strobe_o (modulator_strobe_o)
  );

  // ==========================================================================
  // checks
  property p_digit_range;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_reg.digit <= pcm_tdm_pkg::LAST_DIGIT) && (s_reg.chan <= pcm_tdm_pkg::LAST_CHAN);
  endproperty
  a_digit_range: assert property (p_digit_range)
    else $error("digit or channel counter out of range");

  property p_step_order;
    @(posedge clk_i) disable iff (!rstn_i)
      (timing_o.step != pcm_tdm_pkg::CODE_ZERO) |->
        $onehot(timing_o.step) && timing_o.step[s_reg.digit];
  endproperty
  a_step_order: assert property (p_step_order)
    else $error("step pulse does not match current digit");

  property p_word_first_step;
    @(posedge clk_i) disable iff (!rstn_i)
      timing_o.word_rate_timing |-> timing_o.step[0] && (timing_o.odd_strobe != timing_o.even_strobe);
  endproperty
  a_word_first_step: assert property (p_word_first_step)
    else $error("word start without first step pulse and one line strobe");

  property p_lines_interleave;
    @(posedge clk_i) disable iff (!rstn_i)
      timing_o.odd_strobe |-> (s_reg.chan[0] == 1'b0);
  endproperty
  a_lines_interleave: assert property (p_lines_interleave)
    else $error("odd line strobed on an even channel");

  property p_address_slot;
    @(posedge clk_i) disable iff (!rstn_i)
      (decide_now && (s_reg.chan == pcm_tdm_pkg::LAST_CHAN)
       && (s_reg.digit == pcm_tdm_pkg::LAST_DIGIT)) |=> (pcm_o == $past(address_bit));
  endproperty
  a_address_slot: assert property (p_address_slot)
    else $error("address digit not inserted in last slot");

  property p_master_in_48;
    @(posedge clk_i) disable iff (!rstn_i)
      !system_96_i |-> (address_bit == !s_reg.frame[0]);
  endproperty
  a_master_in_48: assert property (p_master_in_48)
    else $error("48-channel system not using master address");

  property p_code_decision;
    @(posedge clk_i) disable iff (!rstn_i)
      (decide_now
       && !((s_reg.chan == pcm_tdm_pkg::LAST_CHAN) && (s_reg.digit == pcm_tdm_pkg::LAST_DIGIT)))
      |=> (pcm_o == $past(held_code[bit_pos]));
  endproperty
  a_code_decision: assert property (p_code_decision)
    else $error("coder digit differs from sample bit");

  property p_free_run_48;
    @(posedge clk_i) disable iff (!rstn_i)
      (!system_96_i && !digit_tick) |=> (s_reg.acc == $past(acc_sum[16:0]));
  endproperty
  a_free_run_48: assert property (p_free_run_48)
    else $error("48-channel unit disturbed by sync input");

  property p_slave_snap;
    @(posedge clk_i) disable iff (!rstn_i)
      (follow_sync && sync_rise) |=> (s_reg.acc == pcm_tdm_pkg::ACC_HALF) ##1 sync_o;
  endproperty
  a_slave_snap: assert property (p_slave_snap)
    else $error("slave did not lock phase to sync edge");

  property p_sync_out;
    @(posedge clk_i) disable iff (!rstn_i)
      sync_o == $past(s_reg.acc >= pcm_tdm_pkg::ACC_HALF);
  endproperty
  a_sync_out: assert property (p_sync_out)
    else $error("sync output not high in second half of digit");

  property p_digit_period;
    @(posedge clk_i) disable iff (!rstn_i)
      (digit_tick && !system_96_i) |-> ##[54:55] digit_tick;
  endproperty
  a_digit_period: assert property (p_digit_period)
    else $error("free-running digit period off");

  property p_frame_turn;
    @(posedge clk_i) disable iff (!rstn_i)
      (timing_o.word_rate_timing && (s_reg.chan == pcm_tdm_pkg::CHAN_ZERO))
        |-> (s_reg.frame == $past(s_reg.frame) + 2'h1);
  endproperty
  a_frame_turn: assert property (p_frame_turn)
    else $error("frame counter did not advance at channel 0");

  property p_capture;
    @(posedge clk_i) disable iff (!rstn_i)
      timing_o.word_rate_timing |-> (line_sample == $past(audio_i[next_chan]));
  endproperty
  a_capture: assert property (p_capture)
    else $error("coder line does not hold the new channel sample");

  property p_clamp_start;
    @(posedge clk_i) disable iff (!rstn_i)
      timing_o.word_rate_timing |->
        (s_reg.clamp == pcm_tdm_pkg::code_t'(pcm_tdm_pkg::STEP_FIRST << pcm_tdm_pkg::LAST_DIGIT));
  endproperty
  a_clamp_start: assert property (p_clamp_start)
    else $error("word does not start with only the top trial bit");

  property p_channel_rate;
    @(posedge clk_i) disable iff (!rstn_i)
      (timing_o.step[0] |=> timing_o.channel_rate_signal)
      and (timing_o.step[3] |=> !timing_o.channel_rate_signal);
  endproperty
  a_channel_rate: assert property (p_channel_rate)
    else $error("channel rate square out of phase with word");

  property p_lock;
    @(posedge clk_i) disable iff (!rstn_i)
      ((follow_sync && sync_rise) |=> sync_locked_o) and (!follow_sync |-> !sync_locked_o);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock indicator wrong");

  property p_modem_align;
    @(posedge clk_i) disable iff (!rstn_i)
      timing_o.word_rate_timing |=> modulator_strobe_o[$past(s_reg.chan)];
  endproperty
  a_modem_align: assert property (p_modem_align)
    else $error("modulator strobe not on the channel being coded");

  property p_step_from_tick;
    @(posedge clk_i) disable iff (!rstn_i)
      (digit_tick && !(follow_sync && sync_rise)) |=> (timing_o.step != pcm_tdm_pkg::CODE_ZERO);
  endproperty
  a_step_from_tick: assert property (p_step_from_tick)
    else $error("digit edge without step pulse");

  property p_pcm_holds;
    @(posedge clk_i) disable iff (!rstn_i)
      !decide_now |=> $stable(pcm_o);
  endproperty
  a_pcm_holds: assert property (p_pcm_holds)
    else $error("serial digit changed between decisions");

  property p_slave_address;
    @(posedge clk_i) disable iff (!rstn_i)
      (decide_now && !acting_master && (s_reg.chan == pcm_tdm_pkg::LAST_CHAN)
       && (s_reg.digit == pcm_tdm_pkg::LAST_DIGIT)) |=> (pcm_o == !$past(s_reg.frame[1]));
  endproperty
  a_slave_address: assert property (p_slave_address)
    else $error("slave address pattern wrong");

endmodule : pcm_tdm_transmit_framer

`default_nettype wire

// ### bench/line_rx_model.sv
// Purpose : line interface model that takes one digit from the serial pcm stream per digit clock
// Assumes : the digit is decided one clock before the edge that raises the digit clock
// Notes   : the model does not find frame position; the bench aligns words itself

`timescale 1ns/10ps
`default_nettype none

module line_rx_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic pcm_i,
  input  wire logic line_clk_i,
  output logic      digit_o,
  output logic      digit_valid_o
);
  // ==========================================================================
  // digit sampling
  logic line_clk_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_clk_reg  <= 1'b0;
      digit_o       <= 1'b0;
      digit_valid_o <= 1'b0;
    end else begin
      line_clk_reg  <= line_clk_i;
      // sampled one clock after the rise, well inside the digit
      digit_valid_o <= line_clk_i & ~line_clk_reg;
      digit_o       <= pcm_i;
    end
  end
endmodule : line_rx_model

`default_nettype wire

// ### bench/test_pcm_tdm_transmit_framer.sv
// Purpose : self-checking bench of the transmit pcm framer
// Assumes : channel 0 is the first word after reset; sync_i mimics a master unit
// Notes   : six frames in all; a frame is 15625 clocks

`timescale 1ns/10ps
`default_nettype none

module test_pcm_tdm_transmit_framer;
  // ==========================================================================
  // signals
  logic                    clk_i = 1'b0;
  logic                    rstn_i = 1'b0;
  pcm_tdm_pkg::audio_t     audio_i;
  logic                    system_96_i = 1'b0;
  logic                    master_sel_i = 1'b1;
  logic                    sync_i = 1'b0;
  logic                    pcm_o, sync_o, sync_locked_o, digit, digit_valid;
  pcm_tdm_pkg::tx_timing_t timing_o;
  logic [47:0]             modulator_strobe_o;
  logic [17:0]             gen = 18'h00000;
  logic                    sync_run = 1'b1;
  logic                    last_addr;
  int                      error_cnt = 0;
  int                      checks = 0;
  int                      cyc = 0;
  int                      frame_t, last_step, last_dig;

  pcm_tdm_transmit_framer dut (.clk_i(clk_i), .rstn_i(rstn_i), .audio_i(audio_i),
    .system_96_i(system_96_i), .master_sel_i(master_sel_i), .sync_i(sync_i), .pcm_o(pcm_o),
    .sync_o(sync_o), .sync_locked_o(sync_locked_o), .timing_o(timing_o),
    .modulator_strobe_o(modulator_strobe_o));
  line_rx_model rx (.clk_i(clk_i), .rstn_i(rstn_i), .pcm_i(pcm_o), .line_clk_i(sync_o),
    .digit_o(digit), .digit_valid_o(digit_valid));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc++;

  // master unit sync: high in the second half of each digit, one clock late
  always @(posedge clk_i) begin
    #1;
    sync_i = rstn_i && sync_run && (gen >= 18'(pcm_tdm_pkg::ACC_HALF));
    gen = gen + 18'(pcm_tdm_pkg::ACC_STEP);
    if (gen >= 18'(pcm_tdm_pkg::ACC_MOD)) gen = gen - 18'(pcm_tdm_pkg::ACC_MOD);
    if (!rstn_i) gen = 18'h00000;
  end

  // ==========================================================================
  // report and compare
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic cmp1(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : cmp1

  task automatic cmp_vec(input logic [47:0] got, input logic [47:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp_vec

  task automatic cmp_int(input int got, input int lo, input int hi, input string msg);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0d", $time, msg, got);
    end
  endtask : cmp_int

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic give_up(input string msg);
    error_cnt++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    wrap_up();
  endtask : give_up

  // ==========================================================================
  // word and frame walking
  task automatic wait_step(input int d);
    int n;
    n = 0;
    while (timing_o.step[d] !== 1'b1) begin
      tick();
      n++;
      if (n > 200) give_up("step pulse");
    end
  endtask : wait_step

  task automatic wait_digit(output logic b);
    int n;
    n = 0;
    while (digit_valid !== 1'b1) begin
      tick();
      n++;
      if (n > 200) give_up("digit");
    end
    b = digit;
  endtask : wait_digit

  // walks one whole frame from channel 0; timed enables the period checks
  task automatic run_frame(input logic timed, output logic addr);
    logic b;
    for (int c = 0; c < 48; c++) begin
      for (int d = 0; d < 6; d++) begin
        wait_step(d);
        cmp_vec(48'(timing_o.step), 48'(6'h01 << d), "step order");
        if (timed) cmp_int(cyc - last_step, 54, 55, "digit period");
        last_step = cyc;
        if (d == 0) begin
          cmp1(timing_o.word_rate_timing, 1'b1, "word start");
          cmp1(timing_o.odd_strobe, ~c[0], "odd capture");
          cmp1(timing_o.even_strobe, c[0], "even capture");
          if (c == 0 && timed) cmp_int(cyc - frame_t, 15625, 15625, "frame period");
          if (c == 0) frame_t = cyc;
          tick();
          cmp_vec(modulator_strobe_o, 48'h000000000001 << c, "modulator strobe");
        end
        wait_digit(b);
        if (timed) cmp_int(cyc - last_dig, 54, 55, "sync out period");
        last_dig = cyc;
        cmp1(timing_o.channel_rate_signal, d < 3, "channel rate");
        if (c == 47 && d == 5) addr = b;
        else cmp1(b, audio_i[c][7-d], "code digit");
      end
    end
  endtask : run_frame

  // boundary codes on the first channels and on the address channel
  task automatic set_audio(input logic [7:0] base);
    for (int k = 0; k < 48; k++) audio_i[k] = base + 8'(k * 5);
    audio_i[0]  = 8'hFF;
    audio_i[1]  = 8'h00;
    audio_i[47] = 8'hFC;
  endtask : set_audio

  // ==========================================================================
  // scenarios
  task automatic scen_master_48;
    logic a;
    master_sel_i = 1'b0;
    run_frame(1'b0, last_addr);
    set_audio(8'h11);
    run_frame(1'b1, a);
    cmp1(a, ~last_addr, "master address toggles");
    cmp1(sync_locked_o, 1'b0, "lock in 48 mode");
    last_addr = a;
  endtask : scen_master_48

  task automatic scen_master_96;
    logic a;
    system_96_i  = 1'b1;
    master_sel_i = 1'b1;
    set_audio(8'h5A);
    run_frame(1'b1, a);
    cmp1(a, ~last_addr, "master address");
    cmp1(sync_locked_o, 1'b0, "lock as master");
  endtask : scen_master_96

  // slave: address repeats 1100, so two frames apart it is inverted
  task automatic scen_slave_96;
    logic a0, a1, a2;
    master_sel_i = 1'b0;
    set_audio(8'hA7);
    run_frame(1'b0, a0);
    run_frame(1'b0, a1);
    run_frame(1'b0, a2);
    cmp1(a2, ~a0, "slave address");
    cmp1(sync_locked_o, 1'b1, "locked to sync");
    sync_run = 1'b0;
    repeat (260) tick();
    cmp1(sync_locked_o, 1'b0, "lock dropped");
  endtask : scen_slave_96

  initial begin
    set_audio(8'h33);
    repeat (12) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    scen_master_48();
    scen_master_96();
    scen_slave_96();
    wrap_up();
  end
endmodule : test_pcm_tdm_transmit_framer

`default_nettype wire
